/* include/octal_line_channel_control_defines.vh */
// Address map, reset values and bus constants of the register bank
`ifndef OCTAL_LINE_CHANNEL_CONTROL_DEFINES_VH
`define OCTAL_LINE_CHANNEL_CONTROL_DEFINES_VH

// ==========================================
// Register offsets, five decoded address bits
// ==========================================
`define OLC_ADDR_BITS         5
`define OLC_REVISION_ID       5'h00
`define OLC_ANALOG_LOOP_MASK  5'h01
`define OLC_REMOTE_LOOP_MASK  5'h02
`define OLC_ALL_ONES_GEN_MASK 5'h03
`define OLC_SIGNAL_LOSS_STATE 5'h04
`define OLC_DRIVER_FAULT_STATE 5'h05
`define OLC_SIGNAL_LOSS_IRQ_MASK 5'h06
`define OLC_DRIVER_FAULT_IRQ_MASK 5'h07
`define OLC_SIGNAL_LOSS_CHANGE_FLAGS 5'h08
`define OLC_DRIVER_FAULT_CHANGE_FLAGS 5'h09
`define OLC_SOFT_RESET_TRIGGER 5'h0a

// ==========================================
// Widths and reset values
// ==========================================
`define OLC_CHANNELS          8
`define OLC_DATA_BITS         8
`define OLC_REG_RESET         8'h00
`define OLC_READ_UNMAPPED     8'h00
`define OLC_SYNC_STAGES       2

// ==========================================
// Host port synchroniser layout: {csN, rdN, wrN, addr[7:0], data[7:0]}
// ==========================================
`define OLC_BUS_SYNC_BITS     19
`define OLC_BUS_IDLE          19'h70000
`define OLC_BUS_CS_BIT        18
`define OLC_BUS_RD_BIT        17
`define OLC_BUS_WR_BIT        16
`define OLC_BUS_ADDR_HI       15
`define OLC_BUS_ADDR_LO       8
`define OLC_BUS_DATA_HI       7
`define OLC_BUS_DATA_LO       0
`define OLC_LINE_SYNC_BITS    16
`define OLC_LINE_IDLE         16'h0000

`endif

/* verification/host_port_model.sv */
// Host processor model driving the parallel register port
`timescale 1ns/1ps
module host_port_model (
  input  wire       core_clk,
  input  wire [7:0] busDataOut,
  input  wire       busRdy,
  output reg        busCsN,
  output reg        busRdN,
  output reg        busWrN,
  output reg  [7:0] busAddr,
  output reg  [7:0] busDataIn
);
  integer stalls;
  // Idle bus with strobes high
  initial begin
    busCsN    = 1'b1;
    busRdN    = 1'b1;
    busWrN    = 1'b1;
    busAddr   = 8'h00;
    busDataIn = 8'h00;
    stalls    = 0;
  end
  // Ready sampled mid-cycle; a missing answer counts a stall
  task automatic waitRdy(input logic lvl);
    integer n;
    begin
      n = 0;
      @(negedge core_clk);
      while (busRdy !== lvl && n < 32) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (busRdy !== lvl)
        stalls = stalls + 1;
      @(posedge core_clk);
    end
  endtask
  // Write: data held until ready returns
  task automatic writeReg(input [7:0] addr, input [7:0] data);
    begin
      @(posedge core_clk);
      busCsN    <= 1'b0;
      busAddr   <= addr;
      busDataIn <= data;
      busWrN    <= 1'b0;
      waitRdy(1'b0);
      busWrN <= 1'b1;
      waitRdy(1'b1);
      busCsN    <= 1'b1;
      busDataIn <= ~data; // Released bus must not show the old value
      repeat (5) @(negedge core_clk); // Return with outputs settled
    end
  endtask
  // Read: data taken when ready returns
  task automatic readReg(input [7:0] addr, output [7:0] data);
    begin
      @(posedge core_clk);
      busCsN  <= 1'b0;
      busAddr <= addr;
      busRdN  <= 1'b0;
      waitRdy(1'b0);
      waitRdy(1'b1);
      data = busDataOut;
      busRdN <= 1'b1;
      busCsN <= 1'b1;
      repeat (5) @(negedge core_clk);
    end
  endtask
endmodule

/* verification/regs_port_checker_properties.sv */
// Port-level assertions for the register bank
`timescale 1ns/1ps
module regs_port_checker #(
  parameter [3:0] ID_NIBBLE   = 4'h5,
  parameter [3:0] SILICON_REV = 4'h1
) (
  input wire       core_clk,
  input wire       rst_n,
  input wire       busCsN,
  input wire       busRdN,
  input wire       busWrN,
  input wire [7:0] busAddr,
  input wire [7:0] busDataOut,
  input wire       busDataOe,
  input wire       busRdyOe,
  input wire [7:0] signalLoss,
  input wire [7:0] driverFault,
  input wire [7:0] analogLoopEnable,
  input wire [7:0] remoteLoopEnable,
  input wire [7:0] allOnesEnable,
  input wire       intN
);
  reg [3:0]  sinceWr_reg;
  reg [3:0]  sinceRd_reg;
  reg [3:0]  sinceLine_reg;
  reg [15:0] lineLast_reg;
  // ==========================================
  // Saturating ages of strobes and line changes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceWr_reg   <= 4'hf;
      sinceRd_reg   <= 4'hf;
      sinceLine_reg <= 4'hf;
      lineLast_reg  <= 16'h0000;
    end else begin
      sinceWr_reg   <= !busWrN ? 4'h0 : sinceWr_reg + {3'h0, sinceWr_reg != 4'hf};
      sinceRd_reg   <= !busRdN ? 4'h0 : sinceRd_reg + {3'h0, sinceRd_reg != 4'hf};
      sinceLine_reg <= ({signalLoss, driverFault} != lineLast_reg) ? 4'h0 :
                       sinceLine_reg + {3'h0, sinceLine_reg != 4'hf};
      lineLast_reg  <= {signalLoss, driverFault};
    end
  end
  // ==========================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  analog_by_write_a: assert property ($changed(analogLoopEnable) |-> sinceWr_reg <= 4'h7)
    else $error("analog moved without write");
  remote_by_write_a: assert property ($changed(remoteLoopEnable) |-> sinceWr_reg <= 4'h7)
    else $error("remote moved without write");
  ones_by_write_a: assert property ($changed(allOnesEnable) |-> sinceWr_reg <= 4'h7)
    else $error("ones moved without write");
  soft_reset_clears_a: assert property ($rose(busWrN) && !busCsN && busAddr[4:0] == 5'h0a
    |-> ##[1:6] (analogLoopEnable == 8'h00 && remoteLoopEnable == 8'h00
    && allOnesEnable == 8'h00 && intN)) else $error("soft reset incomplete");
  revision_read_a: assert property ($rose(busDataOe) && busAddr[4:0] == 5'h00 |->
    busDataOut == {ID_NIBBLE, SILICON_REV}) else $error("revision value wrong");
  unmapped_zero_a: assert property ($rose(busDataOe) && busAddr[4:0] >= 5'h0a |->
    busDataOut == 8'h00) else $error("unmapped read not zero");
  irq_cause_a: assert property ($fell(intN) |-> sinceLine_reg <= 4'h9 || sinceWr_reg <= 4'h9)
    else $error("interrupt fell uncaused");
  irq_release_a: assert property ($rose(intN) |-> sinceRd_reg <= 4'h9 || sinceWr_reg <= 4'h9)
    else $error("interrupt rose uncaused");
  ready_drive_a: assert property (busRdyOe == !$past(busCsN, 2))
    else $error("ready drive wrong");
  cover property ($fell(intN));
  cover property ($rose(intN));
  cover property ($rose(busDataOe) && busAddr[4:0] == 5'h00);
endmodule

bind octal_line_channel_control_regs regs_port_checker #(
  .ID_NIBBLE(ID_NIBBLE), .SILICON_REV(SILICON_REV)) u_checker (
  .core_clk(core_clk), .rst_n(rst_n), .busCsN(busCsN), .busRdN(busRdN), .busWrN(busWrN),
  .busAddr(busAddr), .busDataOut(busDataOut), .busDataOe(busDataOe), .busRdyOe(busRdyOe),
  .signalLoss(signalLoss), .driverFault(driverFault), .analogLoopEnable(analogLoopEnable),
  .remoteLoopEnable(remoteLoopEnable), .allOnesEnable(allOnesEnable), .intN(intN));

/* verification/testbench.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
module testbench;
  localparam [7:0] REV_ID = 8'h51; // Arbitrary identification value
  reg        core_clk;
  reg        rst_n;
  reg  [7:0] signalLoss;
  reg  [7:0] driverFault;
  wire       busCsN;
  wire       busRdN;
  wire       busWrN;
  wire       busRdy;
  wire [7:0] busAddr;
  wire [7:0] busDataIn;
  wire [7:0] busDataOut;
  wire [7:0] analogLoopEnable;
  wire [7:0] remoteLoopEnable;
  wire [7:0] allOnesEnable;
  wire       intN;
  reg  [7:0] rdData;
  integer    fails;
  integer    comparisons;

  host_port_model host (.core_clk(core_clk), .busDataOut(busDataOut), .busRdy(busRdy),
    .busCsN(busCsN), .busRdN(busRdN), .busWrN(busWrN), .busAddr(busAddr),
    .busDataIn(busDataIn));
  octal_line_channel_control_regs #(.ID_NIBBLE(REV_ID[7:4]), .SILICON_REV(REV_ID[3:0])) dut (
    .core_clk(core_clk), .rst_n(rst_n), .busCsN(busCsN), .busRdN(busRdN), .busWrN(busWrN),
    .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(),
    .busRdy(busRdy), .busRdyOe(), .signalLoss(signalLoss), .driverFault(driverFault),
    .analogLoopEnable(analogLoopEnable), .remoteLoopEnable(remoteLoopEnable),
    .allOnesEnable(allOnesEnable), .intN(intN));

  // ==========================================
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check8(input string what, input [7:0] exp, input [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic expectReg(input [7:0] addr, input [7:0] exp);
    begin
      host.readReg(addr, rdData);
      check8($sformatf("reg %h", addr), exp, rdData);
    end
  endtask
  task automatic checkOuts(input [7:0] al, input [7:0] rl, input [7:0] ao, input irq);
    begin
      check8("analog", al, analogLoopEnable);
      check8("remote", rl, remoteLoopEnable);
      check8("ones", ao, allOnesEnable);
      check8("intN", {7'h00, irq}, {7'h00, intN});
    end
  endtask
  // Line change, then time for sync, flag and interrupt
  task automatic setLine(input logic drv, input [7:0] v);
    begin
      @(posedge core_clk);
      if (drv)
        driverFault <= v;
      else
        signalLoss <= v;
      repeat (8) @(negedge core_clk);
    end
  endtask
  // ==========================================
  task automatic testResetValues;
    integer a;
    begin
      for (a = 0; a <= 10; a = a + 1)
        expectReg(a[7:0], (a == 0) ? REV_ID : 8'h00);
      checkOuts(8'h00, 8'h00, 8'h00, 1'b1);
    end
  endtask
  // Masks drive outputs; alias, read-only and unmapped places
  task automatic testMasks;
    begin
      host.writeReg(8'h01, 8'ha5);
      host.writeReg(8'h02, 8'h3c);
      host.writeReg(8'h03, 8'h81);
      checkOuts(8'ha5, 8'h3c, 8'h81, 1'b1);
      expectReg(8'h02, 8'h3c);
      expectReg(8'he1, 8'ha5);
      host.writeReg(8'h04, 8'hff);
      expectReg(8'h04, 8'h00);
      expectReg(8'h1f, 8'h00);
      host.writeReg(8'h03, 8'h00);
      checkOuts(8'ha5, 8'h3c, 8'h00, 1'b1);
    end
  endtask
  // Status, sticky flags, masked interrupt; only bit 1 is enabled
  task automatic testStatus(input logic drv);
    logic [7:0] base;
    begin
      base = drv ? 8'h05 : 8'h04;
      host.writeReg(base + 8'h02, 8'h02);
      setLine(drv, 8'h82);
      check8("intN", 8'h00, {7'h00, intN});
      expectReg(base, 8'h82);
      expectReg(base + 8'h04, 8'h82);
      check8("intN", 8'h01, {7'h00, intN});
      expectReg(base + 8'h04, 8'h00);
      setLine(drv, 8'h00);
      setLine(drv, 8'h80);
      expectReg(base + 8'h04, 8'h82);
      setLine(drv, 8'h00);
      check8("intN", 8'h01, {7'h00, intN});
      expectReg(base + 8'h04, 8'h80);
      host.writeReg(base + 8'h02, 8'h00);
    end
  endtask
  task automatic testSoftReset;
    integer a;
    begin
      for (a = 1; a <= 3; a = a + 1)
        host.writeReg(a[7:0], 8'hff);
      host.writeReg(8'h06, 8'h01);
      setLine(1'b0, 8'h01);
      setLine(1'b0, 8'h00);
      check8("intN", 8'h00, {7'h00, intN});
      host.writeReg(8'h0a, 8'h5a);
      checkOuts(8'h00, 8'h00, 8'h00, 1'b1);
      for (a = 1; a <= 10; a = a + 1)
        expectReg(a[7:0], 8'h00);
    end
  endtask
  // ==========================================
  task end_of_test;
    begin
      if (fails == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    signalLoss = 8'h00;
    driverFault = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    testResetValues;
    testMasks;
    testStatus(1'b0);
    testStatus(1'b1);
    testSoftReset;
    check8("stalls", 8'h00, host.stalls[7:0]);
    end_of_test;
  end
  // Far beyond the few hundred cycles the run needs
  initial begin
    #(40 * 40000);
    fails = fails + 1;
    end_of_test;
  end
endmodule

/* verilog/change_latch.v */
// Status copy with sticky change flags, set wins over clear
`timescale 1ns/1ps
`include "octal_line_channel_control_defines.vh"
module change_latch #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             rstSyncN,
  input  wire             softReset,
  input  wire [WIDTH-1:0] level,
  input  wire [WIDTH-1:0] clearMask,
  output wire [WIDTH-1:0] state,
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] state_reg;
  reg  [WIDTH-1:0] flags_reg;
  wire [WIDTH-1:0] changed;

  // Either direction of change counts as an event
  assign changed = level ^ state_reg;

  // ==========================================
  // Status follows the line; flags hold until the host clears them
  // ==========================================
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= {WIDTH{1'h0}};
      flags_reg <= {WIDTH{1'h0}};
    end else if (softReset) begin
      state_reg <= {WIDTH{1'h0}};
      flags_reg <= {WIDTH{1'h0}};
    end else begin
      state_reg <= level;
      // Set beats clear so a change during the clearing read is kept
      flags_reg <= (flags_reg & ~clearMask) | changed;
    end
  end

  assign state = state_reg;
  assign flags = flags_reg;

endmodule

/* verilog/octal_line_channel_control_regs.v */
// Host register bank for eight line channels
//
// Summary of operation
// [R1] Revision bits 7:4 return the low nibble of the identification code.
// [R2] Revision bits 3:0 return the silicon revision, which may vary.
// [R3] Analog loopback mask bit n enables analog loopback on channel n.
// [R4] Remote loopback mask bit n enables remote loopback on channel n.
// [R5] All-ones mask bit n switches the all-ones generator of channel n.
// [R6] Line-loss status bit n reads one while channel n has signal loss.
// [R7] Driver-fault status bit n reads one when channel n driver is shorted.
// [R8] Enabled line-loss change drives the active-low interrupt pin low.
// [R9] Enabled driver-fault change drives the active-low interrupt pin low.
// [R10] Line-loss change flag n sets on any change of status bit n.
// [R11] Line-loss change flags stay set until cleared.
// [R12] Driver-fault change flag n sets on any change of status bit n.
// [R13] Driver-fault change flags stay set until cleared.
// [R14] Any soft reset write restores all registers to defaults.
// [R15] All registers of this bank except the revision register read zero after power-up or any reset; the status registers read the synchronised line levels.
// [R16] Only five address bits are decoded across the 32-location map.
// [R17] Host drives the top three address bits to zero; device ignores them.
// [R18] Interrupt releases when no enabled flag remains; reads clear flags.
`timescale 1ns/1ps
`include "octal_line_channel_control_defines.vh"
module octal_line_channel_control_regs #(
  parameter [3:0] ID_NIBBLE   = 4'h5,
  parameter [3:0] SILICON_REV = 4'h1
) (
  input  wire                        core_clk,
  input  wire                        rst_n,
  input  wire                        busCsN,
  input  wire                        busRdN,
  input  wire                        busWrN,
  input  wire [7:0]                  busAddr,
  input  wire [`OLC_DATA_BITS-1:0]   busDataIn,
  output wire [`OLC_DATA_BITS-1:0]   busDataOut,
  output wire                        busDataOe,
  output wire                        busRdy,
  output wire                        busRdyOe,
  input  wire [`OLC_CHANNELS-1:0]    signalLoss,
  input  wire [`OLC_CHANNELS-1:0]    driverFault,
  output wire [`OLC_CHANNELS-1:0]    analogLoopEnable,
  output wire [`OLC_CHANNELS-1:0]    remoteLoopEnable,
  output wire [`OLC_CHANNELS-1:0]    allOnesEnable,
  output wire                        intN
);

  // ID_NIBBLE and SILICON_REV defaults are arbitrary

  // ========================================================================
  // Bus handshake states
  // ========================================================================
  localparam [2:0] BUS_IDLE = 3'h1;
  localparam [2:0] BUS_WAIT = 3'h2;
  localparam [2:0] BUS_DONE = 3'h4;

  // ========================================================================
  // Address decode helper
  // ========================================================================
  // Only the low five address bits take part; the top three are don't care
  function hits;
    input [7:0]               addr;
    input [`OLC_ADDR_BITS-1:0] offset;
    begin
      hits = (addr[`OLC_ADDR_BITS-1:0] == offset); // R16
    end
  endfunction

  // ========================================================================
  // Declarations
  // ========================================================================
  reg  [1:0]                  rstPipe_reg;
  wire                        rstSyncN;
  wire [`OLC_BUS_SYNC_BITS-1:0]  busSync;
  wire [`OLC_LINE_SYNC_BITS-1:0] lineSync;
  wire                        csS;
  wire                        rdS;
  wire                        wrS;
  wire [7:0]                  addrS;
  wire [`OLC_DATA_BITS-1:0]   dataS;
  reg                         csPrev_reg;
  reg                         rdPrev_reg;
  reg                         wrPrev_reg;
  reg  [7:0]                  addrHeld_reg;
  reg  [`OLC_DATA_BITS-1:0]   dataHeld_reg;
  wire                        selected;
  wire                        readStart;
  wire                        readEnd;
  wire                        writeEnd;
  wire                        softReset;
  reg  [2:0]                  busState_reg;
  reg  [2:0]                  busState_next;
  reg  [`OLC_DATA_BITS-1:0]   readData_reg;
  reg                         readOe_reg;
  reg  [`OLC_DATA_BITS-1:0]   readMux;
  reg  [`OLC_CHANNELS-1:0]    analogLoop_reg;
  reg  [`OLC_CHANNELS-1:0]    remoteLoop_reg;
  reg  [`OLC_CHANNELS-1:0]    allOnes_reg;
  reg  [`OLC_CHANNELS-1:0]    lossIrqMask_reg;
  reg  [`OLC_CHANNELS-1:0]    faultIrqMask_reg;
  reg  [`OLC_CHANNELS-1:0]    lossClear;
  reg  [`OLC_CHANNELS-1:0]    faultClear;
  wire [`OLC_CHANNELS-1:0]    lossState;
  wire [`OLC_CHANNELS-1:0]    faultState;
  wire [`OLC_CHANNELS-1:0]    lossFlags;
  wire [`OLC_CHANNELS-1:0]    faultFlags;
  wire                        irqPending;
  reg                         intN_reg;

  // ========================================================================
  // Reset release
  // ========================================================================
  // Assert at once, release through two flops
  // so all flops leave reset on one edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'h1};
    end
  end

  assign rstSyncN = rstPipe_reg[1];

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  // Host port timing is unrelated to core_clk; resync every pin
  sync_bits #(
    .WIDTH     (`OLC_BUS_SYNC_BITS),
    .RESET_VAL (`OLC_BUS_IDLE)
  ) u_busSync (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .asyncIn  ({busCsN, busRdN, busWrN, busAddr, busDataIn}),
    .syncOut  (busSync)
  );

  // Line status comes from another timing domain
  sync_bits #(
    .WIDTH     (`OLC_LINE_SYNC_BITS),
    .RESET_VAL (`OLC_LINE_IDLE)
  ) u_lineSync (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .asyncIn  ({driverFault, signalLoss}),
    .syncOut  (lineSync)
  );

  assign csS   = busSync[`OLC_BUS_CS_BIT];
  assign rdS   = busSync[`OLC_BUS_RD_BIT];
  assign wrS   = busSync[`OLC_BUS_WR_BIT];
  assign addrS = busSync[`OLC_BUS_ADDR_HI:`OLC_BUS_ADDR_LO];
  assign dataS = busSync[`OLC_BUS_DATA_HI:`OLC_BUS_DATA_LO];

  // ========================================================================
  // Strobe edges
  // ========================================================================
  // Previous samples give strobe edges; address and data are held
  // from the strobe's last cycle so a fast release cannot corrupt them
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      csPrev_reg   <= 1'h1;
      rdPrev_reg   <= 1'h1;
      wrPrev_reg   <= 1'h1;
      addrHeld_reg <= 8'h00;
      dataHeld_reg <= `OLC_REG_RESET;
    end else begin
      csPrev_reg <= csS;
      rdPrev_reg <= rdS;
      wrPrev_reg <= wrS;
      if (!csS) begin
        addrHeld_reg <= addrS;
      end
      if (!wrS) begin
        dataHeld_reg <= dataS;
      end
    end
  end

  assign selected  = ~csS;
  assign readStart = selected & ~rdS & rdPrev_reg;
  assign readEnd   = rdS & ~rdPrev_reg & ~csPrev_reg;
  // Data is taken on the rising edge of the write strobe
  assign writeEnd  = wrS & ~wrPrev_reg & ~csPrev_reg;

  // Any value written to the trigger register resets the bank
  assign softReset = writeEnd & hits(addrHeld_reg, `OLC_SOFT_RESET_TRIGGER); // R14

  // ========================================================================
  // Handshake state machine
  // ========================================================================
  // Ready drops on select and rises when the access is done
  always @* begin
    busState_next = busState_reg;
    case (busState_reg)
      BUS_IDLE: begin
        if (selected) begin
          busState_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        if (!selected) begin
          busState_next = BUS_IDLE;
        end else if (readStart || writeEnd || readOe_reg) begin
          busState_next = BUS_DONE;
        end
      end
      BUS_DONE: begin
        if (!selected) begin
          busState_next = BUS_IDLE;
        end
      end
      default: begin
        busState_next = BUS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      busState_reg <= BUS_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // Ready is driven only while the chip is selected
  assign busRdy   = (busState_reg != BUS_WAIT);
  assign busRdyOe = selected;

  // ========================================================================
  // Read multiplexer
  // ========================================================================
  // Unmapped locations 0x0b to 0x1f read as zero
  always @* begin
    readMux = `OLC_READ_UNMAPPED;
    case (addrS[`OLC_ADDR_BITS-1:0]) // R16
      `OLC_REVISION_ID:               readMux = {ID_NIBBLE, SILICON_REV}; // R1 R2
      `OLC_ANALOG_LOOP_MASK:          readMux = analogLoop_reg;
      `OLC_REMOTE_LOOP_MASK:          readMux = remoteLoop_reg;
      `OLC_ALL_ONES_GEN_MASK:         readMux = allOnes_reg;
      `OLC_SIGNAL_LOSS_STATE:         readMux = lossState; // R6
      `OLC_DRIVER_FAULT_STATE:        readMux = faultState; // R7
      `OLC_SIGNAL_LOSS_IRQ_MASK:      readMux = lossIrqMask_reg;
      `OLC_DRIVER_FAULT_IRQ_MASK:     readMux = faultIrqMask_reg;
      `OLC_SIGNAL_LOSS_CHANGE_FLAGS:  readMux = lossFlags;
      `OLC_DRIVER_FAULT_CHANGE_FLAGS: readMux = faultFlags;
      `OLC_SOFT_RESET_TRIGGER:        readMux = `OLC_REG_RESET; // R15
      default:                        readMux = `OLC_READ_UNMAPPED;
    endcase
  end

  // ========================================================================
  // Read data capture and bus drive
  // ========================================================================
  // Data is frozen at read start so the value cleared at its end
  // is exactly what the host saw
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      readData_reg <= `OLC_REG_RESET;
      readOe_reg   <= 1'h0;
    end else begin
      if (readStart) begin
        readData_reg <= readMux;
      end
      if (readStart) begin
        readOe_reg <= 1'h1;
      end else if (readEnd || !selected) begin
        readOe_reg <= 1'h0;
      end
    end
  end

  assign busDataOut = readData_reg;
  assign busDataOe  = readOe_reg;

  // ========================================================================
  // Read-to-clear of the change flags
  // ========================================================================
  // Only the bits returned to the host are cleared, at the end of the read
  always @* begin
    lossClear  = {`OLC_CHANNELS{1'h0}};
    faultClear = {`OLC_CHANNELS{1'h0}};
    if (readEnd && hits(addrHeld_reg, `OLC_SIGNAL_LOSS_CHANGE_FLAGS)) begin
      lossClear = readData_reg; // R18
    end
    if (readEnd && hits(addrHeld_reg, `OLC_DRIVER_FAULT_CHANGE_FLAGS)) begin
      faultClear = readData_reg; // R18
    end
  end

  // ========================================================================
  // Control registers
  // ========================================================================
  // Writes land on the rising write strobe; soft reset clears everything
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      analogLoop_reg   <= `OLC_REG_RESET; // R15
      remoteLoop_reg   <= `OLC_REG_RESET;
      allOnes_reg      <= `OLC_REG_RESET;
      lossIrqMask_reg  <= `OLC_REG_RESET;
      faultIrqMask_reg <= `OLC_REG_RESET;
    end else if (softReset) begin
      analogLoop_reg   <= `OLC_REG_RESET; // R14
      remoteLoop_reg   <= `OLC_REG_RESET;
      allOnes_reg      <= `OLC_REG_RESET;
      lossIrqMask_reg  <= `OLC_REG_RESET;
      faultIrqMask_reg <= `OLC_REG_RESET;
    end else if (writeEnd) begin
      if (hits(addrHeld_reg, `OLC_ANALOG_LOOP_MASK)) begin
        analogLoop_reg <= dataHeld_reg; // R3
      end
      if (hits(addrHeld_reg, `OLC_REMOTE_LOOP_MASK)) begin
        remoteLoop_reg <= dataHeld_reg; // R4
      end
      if (hits(addrHeld_reg, `OLC_ALL_ONES_GEN_MASK)) begin
        allOnes_reg <= dataHeld_reg; // R5
      end
      if (hits(addrHeld_reg, `OLC_SIGNAL_LOSS_IRQ_MASK)) begin
        lossIrqMask_reg <= dataHeld_reg;
      end
      if (hits(addrHeld_reg, `OLC_DRIVER_FAULT_IRQ_MASK)) begin
        faultIrqMask_reg <= dataHeld_reg;
      end
    end
  end

  // Per-channel controls to the line channels
  assign analogLoopEnable = analogLoop_reg; // R3
  assign remoteLoopEnable = remoteLoop_reg; // R4
  assign allOnesEnable    = allOnes_reg; // R5

  // ========================================================================
  // Status and change tracking
  // ========================================================================
  // Signal loss status and its sticky change flags
  change_latch #(
    .WIDTH (`OLC_CHANNELS)
  ) u_lossLatch (
    .core_clk  (core_clk),
    .rstSyncN  (rstSyncN),
    .softReset (softReset),
    .level     (lineSync[`OLC_CHANNELS-1:0]),
    .clearMask (lossClear),
    .state     (lossState),
    .flags     (lossFlags)
  ); // R6 R10 R11

  // Driver fault status and its sticky change flags
  change_latch #(
    .WIDTH (`OLC_CHANNELS)
  ) u_faultLatch (
    .core_clk  (core_clk),
    .rstSyncN  (rstSyncN),
    .softReset (softReset),
    .level     (lineSync[`OLC_LINE_SYNC_BITS-1:`OLC_CHANNELS]),
    .clearMask (faultClear),
    .state     (faultState),
    .flags     (faultFlags)
  ); // R7 R12 R13

  // ========================================================================
  // Interrupt output
  // ========================================================================
  // Any enabled flag holds the pin low; registered to stay glitch free
  assign irqPending = |(lossFlags & lossIrqMask_reg) // R8
                    | |(faultFlags & faultIrqMask_reg); // R9

  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      intN_reg <= 1'h1;
    end else begin
      intN_reg <= ~irqPending; // R18
    end
  end

  assign intN = intN_reg;

endmodule

/* verilog/sync_bits.v */
// Two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
module sync_bits #(
  parameter WIDTH     = 8,
  parameter RESET_VAL = 8'h00
) (
  input  wire             core_clk,
  input  wire             rstSyncN,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // ==========================================
  // Two flops; only the second stage is read downstream
  // ==========================================
  always @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule
